// ---- src/fa_dma_pkg.sv ----
// Purpose: shared constants and carriers for the full address dma channel pair
// Assumes: 32-bit ahb-lite register bus, 24-bit transfer addresses
// Notes:   register offsets are byte addresses, one word each
package fa_dma_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_SOURCE_ADDRESS      = 8'h00;
	localparam logic [7:0] OFS_DESTINATION_ADDRESS = 8'h04;
	localparam logic [7:0] OFS_BLOCK_SIZE          = 8'h08;
	localparam logic [7:0] OFS_BLOCK_COUNT         = 8'h0C;
	localparam logic [7:0] OFS_TRANSFER_CTRL       = 8'h10;
	localparam logic [7:0] OFS_CHANNEL_CTRL        = 8'h14;
	localparam logic [7:0] OFS_STATUS              = 8'h18;

	// transfer_ctrl_reg fields
	localparam int TC_SIZE_WORD    = 0;
	localparam int TC_SRC_DEC      = 1;
	localparam int TC_SRC_STEP     = 2;
	localparam int TC_DST_DEC      = 3;
	localparam int TC_DST_STEP     = 4;
	localparam int TC_BLOCK_MODE   = 5;
	localparam int TC_BLOCK_SRC    = 6;
	localparam int TC_BURST        = 7;
	localparam int TC_AUTO_REQ     = 8;
	localparam int TC_SRC_SEL_LSB  = 9;
	localparam int TC_WIDTH        = 13;

	// channel_ctrl_reg fields
	localparam int CC_FULL_ADDR    = 0;
	localparam int CC_XFER_EN      = 1;
	localparam int CC_MASTER_EN    = 2;
	localparam int CC_END_IRQ_EN   = 3;
	localparam int CC_EDGE_ACT     = 4;
	localparam int CC_WIDTH        = 5;

	// activation source select codes
	localparam logic [3:0] SRC_EXTERNAL   = 4'h0;
	localparam logic [3:0] SRC_SERIAL_TX  = 4'h1;
	localparam logic [3:0] SRC_SERIAL_RX  = 4'h2;
	localparam logic [3:0] SRC_TIMER_BASE = 4'h3;

	localparam logic [TC_WIDTH-1:0] TC_RESET = 13'h0000;
	localparam logic [CC_WIDTH-1:0] CC_RESET = 5'h00;
	localparam logic [23:0]         ADDR_RESET = 24'h00_0000;
	localparam logic [7:0]          SIZE_RESET = 8'h00;
	localparam logic [15:0]         COUNT_RESET = 16'h0000;
	localparam logic [8:0]          BLOCK_FULL = 9'h100;
	localparam int                  TIMER_CHANNELS = 6;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        word;
		logic [23:0] addr;
		logic [15:0] wdata;
	} bus_cyc_s;

endpackage

// ---- src/full_address_dma_channel.sv ----
// Purpose: full address dma channel pair, normal and block transfer modes
// Assumes: bus controller grants the bus and acknowledges each cycle with done
// Notes:   one clock domain; request pin is asynchronous and synchronised
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

module full_address_dma_channel
	import fa_dma_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      hsel_i,
	input  wire logic [31:0]               haddr_i,
	input  wire logic [1:0]                htrans_i,
	input  wire logic                      hwrite_i,
	input  wire logic [2:0]                hsize_i,
	input  wire logic [31:0]               hwdata_i,
	input  wire logic                      hready_i,
	output logic      [31:0]               hrdata_o,
	output logic                           hreadyout_o,
	output logic                           hresp_o,
	input  wire logic                      external_request_pin_n_i,
	input  wire logic                      serial_tx_done_i,
	input  wire logic                      serial_rx_done_i,
	input  wire logic [TIMER_CHANNELS-1:0] timer_match_i,
	input  wire logic                      nmi_i,
	output logic                           bus_req_o,
	input  wire logic                      bus_grant_i,
	output bus_cyc_s                       cyc_o,
	input  wire logic                      cyc_done_i,
	input  wire logic [15:0]               cyc_rdata_i,
	output logic                           dead_cycle_o,
	output logic                           transfer_end_output_n_o,
	output logic                           end_irq_o
);

	typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_READ, ST_WRITE, ST_DEAD, ST_RELEASE} dma_state_e;

	dma_state_e           state_q;
	logic [23:0]          src_addr_q;
	logic [23:0]          dst_addr_q;
	logic [7:0]           size_hold_q;
	logic [7:0]           size_cnt_q;
	logic [15:0]          blk_cnt_q;
	logic [TC_WIDTH-1:0]  tctrl_q;
	logic [CC_WIDTH-1:0]  cctrl_q;
	logic                 end_flag_q;
	logic                 pend_q;
	logic                 accept_q;
	logic                 high_seen_q;
	logic                 pin_meta_q;
	logic                 pin_n_q;
	logic                 transfer_end_output_n_q;
	logic                 dead_q;
	bus_cyc_s             cyc_q;

	// ahb-lite slave
	logic                 wr_pend_q;
	logic [7:0]           wr_addr_q;
	logic [31:0]          rdata_q;
	logic                 addr_phase;
	logic                 wr_src;
	logic                 wr_dst;
	logic                 wr_size;
	logic                 wr_cnt;
	logic                 wr_tctrl;
	logic                 wr_cctrl;

	// datapath helpers
	logic                 normal_mode;
	logic                 block_mode;
	logic                 active;
	logic                 auto_req;
	logic                 src_event;
	logic                 request;
	logic                 write_done;
	logic                 block_last;
	logic                 count_last;
	logic                 last_xfer;
	logic                 burst_on;
	logic [23:0]          src_next;
	logic [23:0]          dst_next;
	logic [23:0]          step;
	logic [23:0]          span;
	logic [8:0]           blk_units;
	logic [3:0]           src_sel;

	assign addr_phase = hsel_i & hready_i & htrans_i[1];
	assign wr_src     = wr_pend_q & (wr_addr_q == OFS_SOURCE_ADDRESS);
	assign wr_dst     = wr_pend_q & (wr_addr_q == OFS_DESTINATION_ADDRESS);
	assign wr_size    = wr_pend_q & (wr_addr_q == OFS_BLOCK_SIZE);
	assign wr_cnt     = wr_pend_q & (wr_addr_q == OFS_BLOCK_COUNT);
	assign wr_tctrl   = wr_pend_q & (wr_addr_q == OFS_TRANSFER_CTRL);
	assign wr_cctrl   = wr_pend_q & (wr_addr_q == OFS_CHANNEL_CTRL);

	// zero wait states, every response OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= addr_phase & hwrite_i;
			wr_addr_q <= {haddr_i[7:2], 2'b00};
		end
	end

	// read data latched in the address phase; unmapped offsets read zero
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 32'h0000_0000;
		else if (addr_phase & ~hwrite_i)
		begin
			unique case ({haddr_i[7:2], 2'b00})
				OFS_SOURCE_ADDRESS:      rdata_q <= {8'h00, src_addr_q};
				OFS_DESTINATION_ADDRESS: rdata_q <= {8'h00, dst_addr_q};
				OFS_BLOCK_SIZE:          rdata_q <= {16'h0000, size_hold_q, size_cnt_q};
				OFS_BLOCK_COUNT:         rdata_q <= {16'h0000, blk_cnt_q};
				OFS_TRANSFER_CTRL:       rdata_q <= {19'h0_0000, tctrl_q};
				OFS_CHANNEL_CTRL:        rdata_q <= {27'h000_0000, cctrl_q};
				OFS_STATUS:              rdata_q <= {25'h000_0000, state_q, high_seen_q, accept_q, pend_q, end_flag_q};
				default:                 rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign normal_mode = cctrl_q[CC_FULL_ADDR] & ~tctrl_q[TC_BLOCK_MODE];
	assign block_mode  = cctrl_q[CC_FULL_ADDR] & tctrl_q[TC_BLOCK_MODE];
	assign active      = cctrl_q[CC_XFER_EN] & cctrl_q[CC_MASTER_EN] & cctrl_q[CC_FULL_ADDR];
	assign auto_req    = normal_mode & tctrl_q[TC_AUTO_REQ];
	assign burst_on    = auto_req & tctrl_q[TC_BURST];
	assign src_sel     = tctrl_q[TC_SRC_SEL_LSB +: 4];

	// internal activation sources, block mode only
	always_comb
	begin
		src_event = 1'b0;
		if (block_mode)
		begin
			unique case (src_sel)
				SRC_SERIAL_TX: src_event = serial_tx_done_i;
				SRC_SERIAL_RX: src_event = serial_rx_done_i;
				default:
				begin
					if (src_sel >= SRC_TIMER_BASE && src_sel < SRC_TIMER_BASE + 4'(TIMER_CHANNELS))
						src_event = timer_match_i[3'(src_sel - SRC_TIMER_BASE)];
				end
			endcase
		end
	end

	assign request = active & (auto_req | pend_q);

	// two flops before the pin is looked at
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta_q <= 1'b1;
			pin_n_q    <= 1'b1;
		end
		else
		begin
			pin_meta_q <= external_request_pin_n_i;
			pin_n_q    <= pin_meta_q;
		end
	end

	assign write_done = (state_q == ST_WRITE) & cyc_done_i;
	assign block_last = block_mode & (size_cnt_q == 8'h01);
	assign count_last = blk_cnt_q == 16'h0001;
	assign last_xfer  = block_mode ? (block_last & count_last) : count_last;

	// pending request and acceptance window of the pin
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pend_q      <= 1'b0;
			accept_q    <= 1'b0;
			high_seen_q <= 1'b0;
		end
		else if (wr_cctrl && hwdata_i[CC_XFER_EN] && !cctrl_q[CC_XFER_EN])
		begin
			// sampling begins on the edge after the enabling write
			pend_q      <= 1'b0;
			accept_q    <= 1'b1;
			high_seen_q <= 1'b0;
		end
		else if (state_q == ST_IDLE && request)
		begin
			pend_q      <= 1'b0;
			accept_q    <= 1'b0;
			high_seen_q <= 1'b0;
		end
		else
		begin
			if (src_sel == SRC_EXTERNAL && !auto_req)
			begin
				if (accept_q && !pin_n_q)
					pend_q <= 1'b1;
			end
			else if (src_event)
				pend_q <= 1'b1;
			if (!accept_q && pin_n_q && state_q != ST_IDLE)
				high_seen_q <= 1'b1;
			if (cctrl_q[CC_EDGE_ACT])
			begin
				if (normal_mode && write_done && (high_seen_q || pin_n_q))
					accept_q <= 1'b1;
				else if (block_mode && state_q == ST_DEAD && (high_seen_q || pin_n_q))
					accept_q <= 1'b1;
				else if (!accept_q && state_q == ST_IDLE && pin_n_q)
					accept_q <= 1'b1;
			end
			else if (state_q == ST_DEAD || (normal_mode && write_done && !count_last))
				accept_q <= 1'b1;
		end
	end

	// address stepping
	assign step      = tctrl_q[TC_SIZE_WORD] ? 24'h00_0002 : 24'h00_0001;
	assign blk_units = (size_hold_q == 8'h00) ? BLOCK_FULL : {1'b0, size_hold_q};
	assign span      = tctrl_q[TC_SIZE_WORD] ? {14'h0000, blk_units, 1'b0} : {15'h0000, blk_units};

	always_comb
	begin
		src_next = src_addr_q;
		dst_next = dst_addr_q;
		if (tctrl_q[TC_SRC_STEP])
			src_next = tctrl_q[TC_SRC_DEC] ? src_addr_q - step : src_addr_q + step;
		if (tctrl_q[TC_DST_STEP])
			dst_next = tctrl_q[TC_DST_DEC] ? dst_addr_q - step : dst_addr_q + step;
		// block area goes back to its start at the end of each block
		if (block_last && tctrl_q[TC_BLOCK_SRC] && tctrl_q[TC_SRC_STEP])
			src_next = tctrl_q[TC_SRC_DEC] ? src_addr_q - step + span : src_addr_q + step - span;
		if (block_last && !tctrl_q[TC_BLOCK_SRC] && tctrl_q[TC_DST_STEP])
			dst_next = tctrl_q[TC_DST_DEC] ? dst_addr_q - step + span : dst_addr_q + step - span;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			src_addr_q <= ADDR_RESET;
			dst_addr_q <= ADDR_RESET;
		end
		else if (write_done)
		begin
			src_addr_q <= src_next;
			dst_addr_q <= dst_next;
		end
		else
		begin
			if (wr_src)
				src_addr_q <= hwdata_i[23:0];
			if (wr_dst)
				dst_addr_q <= hwdata_i[23:0];
		end
	end

	// size and block counters; value 0 means full range
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			size_hold_q <= SIZE_RESET;
			size_cnt_q  <= SIZE_RESET;
			blk_cnt_q   <= COUNT_RESET;
		end
		else if (write_done)
		begin
			if (block_mode)
			begin
				size_cnt_q <= block_last ? size_hold_q : size_cnt_q - 8'h01;
				if (block_last)
					blk_cnt_q <= blk_cnt_q - 16'h0001;
			end
			else
				blk_cnt_q <= blk_cnt_q - 16'h0001;
		end
		else
		begin
			if (wr_size)
			begin
				size_hold_q <= hwdata_i[15:8];
				size_cnt_q  <= hwdata_i[7:0];
			end
			if (wr_cnt)
				blk_cnt_q <= hwdata_i[15:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			tctrl_q <= TC_RESET;
		else if (wr_tctrl)
			tctrl_q <= hwdata_i[TC_WIDTH-1:0];
	end

	// hardware clears win over a software write in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cctrl_q <= CC_RESET;
		else
		begin
			if (wr_cctrl)
				cctrl_q <= hwdata_i[CC_WIDTH-1:0];
			if (write_done && last_xfer)
				cctrl_q[CC_XFER_EN] <= 1'b0;
			if (nmi_i && burst_on && cctrl_q[CC_XFER_EN])
				cctrl_q[CC_MASTER_EN] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			end_flag_q <= 1'b0;
		else if (write_done && last_xfer)
			end_flag_q <= 1'b1;
		else if (wr_cctrl && hwdata_i[CC_XFER_EN])
			end_flag_q <= 1'b0;
	end

	assign end_irq_o = end_flag_q & cctrl_q[CC_END_IRQ_EN];

	// transfer sequencer
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= ST_IDLE;
		else
		begin
			unique case (state_q)
				ST_IDLE:
					if (request)
						state_q <= ST_ARB;
				ST_ARB:
					if (bus_grant_i)
						state_q <= ST_READ;
				ST_READ:
					if (cyc_done_i)
						state_q <= ST_WRITE;
				ST_WRITE:
					if (cyc_done_i)
					begin
						if (last_xfer || block_last)
							state_q <= ST_DEAD;
						else if (block_mode)
							state_q <= ST_READ;
						else if (burst_on && cctrl_q[CC_MASTER_EN])
							state_q <= ST_READ;
						else
							state_q <= ST_RELEASE;
					end
				ST_DEAD:
					state_q <= ST_RELEASE;
				ST_RELEASE:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// bus held from grant through the dead state, so nothing can preempt
	assign bus_req_o    = (state_q == ST_ARB) | (state_q == ST_READ) | (state_q == ST_WRITE) |
	                      (state_q == ST_DEAD);
	assign dead_cycle_o = dead_q;
	assign transfer_end_output_n_o = transfer_end_output_n_q;
	assign cyc_o        = cyc_q;

	// cycle command register, every field registered, with the dead cycle and end mark flops
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cyc_q    <= '0;
			dead_q   <= 1'b0;
			transfer_end_output_n_q <= 1'b1;
		end
		else
		begin
			dead_q  <= write_done & (last_xfer | block_last);
			if ((state_q == ST_ARB && bus_grant_i) || (write_done && state_q == ST_WRITE &&
			    !(last_xfer || block_last) && (block_mode || (burst_on && cctrl_q[CC_MASTER_EN]))))
			begin
				cyc_q.valid <= 1'b1;
				cyc_q.write <= 1'b0;
				cyc_q.addr  <= write_done ? src_next : src_addr_q;
				transfer_end_output_n_q    <= 1'b1;
			end
			else if (state_q == ST_READ && cyc_done_i)
			begin
				cyc_q.write <= 1'b1;
				cyc_q.addr  <= dst_addr_q;
				cyc_q.wdata <= cyc_rdata_i;
				transfer_end_output_n_q    <= ~last_xfer;
			end
			else if (write_done)
			begin
				cyc_q.valid <= 1'b0;
				transfer_end_output_n_q    <= 1'b1;
			end
			cyc_q.word <= tctrl_q[TC_SIZE_WORD];
		end
	end

endmodule // full_address_dma_channel

// ---- sim/dma_bus_model.sv ----
// Purpose: bus controller model facing the dma channel
// Assumes: done is a one-clock pulse for each bus cycle
// Notes:   grant and done delays vary from prompt to slow
`timescale 1ns/1ps

module dma_bus_model
	import fa_dma_pkg::*;
(
	input  wire logic     clk_i,
	input  wire logic     rst_n_i,
	input  wire logic     bus_req_i,
	input  wire bus_cyc_s cyc_i,
	output logic          bus_grant_o,
	output logic          cyc_done_o,
	output logic [15:0]   cyc_rdata_o
);
	logic [7:0] lfsr_q;
	logic [1:0] wait_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lfsr_q      <= 8'h5b;
			wait_q      <= 2'h0;
			bus_grant_o <= 1'b0;
			cyc_done_o  <= 1'b0;
			cyc_rdata_o <= 16'h0000;
		end
		else
		begin
			lfsr_q      <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			bus_grant_o <= bus_req_i && (bus_grant_o || lfsr_q[0]);
			cyc_done_o  <= 1'b0;
			// stale data flips so it never passes for fresh
			cyc_rdata_o <= ~cyc_rdata_o;
			if (cyc_done_o)
				wait_q <= lfsr_q[2:1];
			else if (cyc_i.valid && bus_grant_o && wait_q == 2'h0)
			begin
				cyc_done_o  <= 1'b1;
				cyc_rdata_o <= {cyc_i.addr[7:0], ~cyc_i.addr[7:0]};
			end
			else if (cyc_i.valid && bus_grant_o)
				wait_q <= wait_q - 2'h1;
		end
	end
endmodule // dma_bus_model

// ---- sim/fa_dma_assertions.sv ----
// Purpose: port-level checks of the dma channel handshakes
// Assumes: bound into every channel instance
// Notes:   register contents are invisible here, only port timing and write data
`timescale 1ns/1ps

module fa_dma_assertions
	import fa_dma_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        bus_req_o,
	input wire bus_cyc_s    cyc_o,
	input wire logic        cyc_done_i,
	input wire logic [15:0] cyc_rdata_i,
	input wire logic        dead_cycle_o,
	input wire logic        transfer_end_output_n_o
);
	default clocking dflt @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_read_done;
		cyc_o.valid && !cyc_o.write && cyc_done_i;
	endsequence
	sequence s_last_write_done;
		cyc_o.valid && cyc_o.write && cyc_done_i && !transfer_end_output_n_o;
	endsequence

	property p_read_then_write;
		s_read_done |=> cyc_o.valid && cyc_o.write;
	endproperty
	a_read_then_write: assert property (p_read_then_write) else $error("no write after read");
	property p_write_copies_read;
		s_read_done |=> cyc_o.wdata == $past(cyc_rdata_i);
	endproperty
	a_write_copies_read: assert property (p_write_copies_read) else $error("write data differs");
	property p_cycle_holds_bus;
		cyc_o.valid |-> bus_req_o;
	endproperty
	a_cycle_holds_bus: assert property (p_cycle_holds_bus) else $error("bus dropped in cycle");
	property p_cycle_stands;
		cyc_o.valid && !cyc_done_i |=> $stable(cyc_o);
	endproperty
	a_cycle_stands: assert property (p_cycle_stands) else $error("cycle changed early");
	property p_dead_after_end;
		s_last_write_done |-> ##[1:2] dead_cycle_o;
	endproperty
	a_dead_after_end: assert property (p_dead_after_end) else $error("no dead state");
	property p_dead_single;
		dead_cycle_o |=> !dead_cycle_o;
	endproperty
	a_dead_single: assert property (p_dead_single) else $error("dead state too long");
	property p_dead_idle_bus;
		dead_cycle_o |-> !cyc_o.valid;
	endproperty
	a_dead_idle_bus: assert property (p_dead_idle_bus) else $error("cycle in dead state");
	property p_release_after_dead;
		dead_cycle_o |-> ##[0:2] !bus_req_o;
	endproperty
	a_release_after_dead: assert property (p_release_after_dead) else $error("bus kept after dead");
	property p_end_in_write;
		!transfer_end_output_n_o |-> cyc_o.valid && cyc_o.write;
	endproperty
	a_end_in_write: assert property (p_end_in_write) else $error("end mark outside write");
endmodule // fa_dma_assertions

bind full_address_dma_channel fa_dma_assertions fa_dma_assertions_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.bus_req_o(bus_req_o), .cyc_o(cyc_o), .cyc_done_i(cyc_done_i), .cyc_rdata_i(cyc_rdata_i),
	.dead_cycle_o(dead_cycle_o), .transfer_end_output_n_o(transfer_end_output_n_o));

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the full address dma channel
// Assumes: zero-wait register slave, bus model on the far side
// Notes:   random addresses and sizes from a fixed seed
`timescale 1ns/1ps

module testbench
	import fa_dma_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        pin_n = 1'b1;
	logic        tx = 1'b0;
	logic        rx = 1'b0;
	logic [5:0]  tmr = 6'h00;
	logic        nmi = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        bus_req;
	logic        grant;
	bus_cyc_s    cyc;
	logic        done;
	logic [15:0] rdata;
	logic        dead;
	logic        irq;
	logic        req_q = 1'b0;
	logic [31:0] seed = 32'h05e3_1bdf;
	logic [23:0] wq[$];
	logic [23:0] rq[$];
	logic [15:0] dq[$];
	int          deads = 0;
	int          releases = 0;
	int          miscompares = 0;
	int          n_tests = 0;

	full_address_dma_channel full_address_dma_channel_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.external_request_pin_n_i(pin_n), .serial_tx_done_i(tx), .serial_rx_done_i(rx), .timer_match_i(tmr),
		.nmi_i(nmi), .bus_req_o(bus_req), .bus_grant_i(grant), .cyc_o(cyc), .cyc_done_i(done),
		.cyc_rdata_i(rdata), .dead_cycle_o(dead), .transfer_end_output_n_o(), .end_irq_o(irq));
	dma_bus_model dma_bus_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req), .cyc_i(cyc),
		.bus_grant_o(grant), .cyc_done_o(done), .cyc_rdata_o(rdata));

	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		req_q <= bus_req;
		if (req_q && !bus_req)
			releases++;
		if (dead)
			deads++;
		if (done && cyc.valid && cyc.write)
		begin
			wq.push_back(cyc.addr);
			dq.push_back(cyc.wdata);
		end
		if (done && cyc.valid && !cyc.write)
			rq.push_back(cyc.addr);
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [23:0] step(input logic [23:0] a, input logic en, input logic dec, input logic word);
		logic [23:0] n;
		n = word ? 24'h00_0002 : 24'h00_0001;
		if (!en)
			return a;
		return dec ? a - n : a + n;
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		do
			@(posedge clk_i);
		while (hreadyout !== 1'b1 && ++n < 50);
		if (n >= 50)
		begin
			chk(32'h0, 32'h1, "bus hang");
			tally_and_finish();
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0000_0000, "response");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task automatic start(input logic [12:0] tc, input logic [23:0] s, input logic [23:0] d, input logic [7:0] sz,
		input logic [15:0] cnt, input logic [4:0] cc);
		wr(OFS_CHANNEL_CTRL, 32'h0000_0000);
		wr(OFS_SOURCE_ADDRESS, {8'h00, s});
		wr(OFS_DESTINATION_ADDRESS, {8'h00, d});
		wr(OFS_BLOCK_SIZE, {16'h0000, sz, sz});
		wr(OFS_BLOCK_COUNT, {16'h0000, cnt});
		wr(OFS_TRANSFER_CTRL, {19'h0_0000, tc});
		wq.delete();
		rq.delete();
		dq.delete();
		deads = 0;
		releases = 0;
		wr(OFS_CHANNEL_CTRL, {27'h000_0000, cc});
	endtask

	task automatic wait_dead(input int want);
		int n;
		for (n = 0; n < 3000 && deads < want; n++)
			@(posedge clk_i);
		repeat (3) @(posedge clk_i);
		chk(32'(deads), 32'(want), "dead count");
		if (deads < want)
			tally_and_finish();
	endtask

	task automatic activate(input int c);
		pin_n <= (c != 0);
		tx <= (c == 1);
		rx <= (c == 2);
		tmr <= (c > 2) ? 6'(1 << (c - 3)) : 6'h00;
		nmi <= (c == 5);
		@(posedge clk_i);
		pin_n <= 1'b1;
		tx <= 1'b0;
		rx <= 1'b0;
		tmr <= 6'h00;
		nmi <= 1'b0;
	endtask

	task automatic expect_xfers(input logic [12:0] tc, input logic [23:0] s, input logic [23:0] d, input int units,
		input int blk);
		logic [23:0] sa;
		logic [23:0] da;
		logic [23:0] s0;
		logic [23:0] d0;
		int i;
		sa = s;
		da = d;
		s0 = s;
		d0 = d;
		chk(32'(wq.size()), 32'(units), "count");
		for (i = 0; i < units && i < wq.size() && i < rq.size(); i++)
		begin
			chk({8'h00, rq[i]}, {8'h00, sa}, "src");
			chk({8'h00, wq[i]}, {8'h00, da}, "dst");
			chk({16'h0000, dq[i]}, {16'h0000, sa[7:0], ~sa[7:0]}, "data");
			sa = step(sa, tc[TC_SRC_STEP], tc[TC_SRC_DEC], tc[TC_SIZE_WORD]);
			da = step(da, tc[TC_DST_STEP], tc[TC_DST_DEC], tc[TC_SIZE_WORD]);
			if (blk != 0 && (i + 1) % blk == 0)
			begin
				// only the block area side snaps back
				if (tc[TC_BLOCK_SRC])
					sa = s0;
				else
					da = d0;
				s0 = sa;
				d0 = da;
			end
		end
	endtask

	initial
	begin
		logic [31:0] x;
		logic [23:0] s;
		logic [23:0] d;
		logic [12:0] tc;
		int i;
		int n;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			ahb(1'b0, 8'(i * 4), 32'h0000_0000, x);
			chk(x, 32'h0000_0000, "reset value");
		end
		wr(8'h1c, 32'hffff_ffff);
		ahb(1'b0, 8'h1c, 32'h0000_0000, x);
		chk(x, 32'h0000_0000, "unmapped");
		$display("test registers done");
		s = 24'(rnd()) & 24'hff_fff0;
		d = 24'(rnd()) & 24'hff_fff0;
		n = 2 + int'(rnd() % 4);
		start(13'h011d, s, d, 8'h00, 16'(n), 5'h0f);
		wait_dead(1);
		expect_xfers(13'h011d, s, d, n, 0);
		chk(32'(releases), 32'(n), "cycle steal");
		chk({31'h0, irq}, 32'h0000_0001, "end irq");
		ahb(1'b0, OFS_CHANNEL_CTRL, 32'h0000_0000, x);
		chk(x, 32'h0000_000d, "enable cleared");
		ahb(1'b0, OFS_SOURCE_ADDRESS, 32'h0000_0000, x);
		chk(x, {8'h00, s + 24'(2 * n)}, "final src");
		$display("test cycle steal done");
		start(13'h0190, s, d, 8'h00, 16'h0004, 5'h07);
		wait_dead(1);
		expect_xfers(13'h0190, s, d, 4, 0);
		chk(32'(releases), 32'h1, "burst held");
		chk({31'h0, irq}, 32'h0000_0000, "irq masked");
		$display("test burst done");
		for (i = 0; i < 9; i++)
		begin
			s = 24'(rnd()) & 24'hff_fff0;
			d = 24'(rnd()) & 24'hff_fff0;
			n = 1 + int'(rnd() % 3);
			tc = {4'(i), 9'h036} | (i[0] ? 13'h0040 : 13'h0000);
			start(tc, s, d, 8'(n), 16'h0002, 5'h1f);
			activate(i);
			wait_dead(1);
			activate(i);
			wait_dead(2);
			expect_xfers(tc, s, d, 2 * n, n);
			chk(32'(releases), 32'h2, "block release");
			chk({31'h0, irq}, 32'h0000_0001, "block end");
		end
		$display("test block done");
		start(13'h0195, s, d, 8'h00, 16'h0010, 5'h07);
		for (n = 0; n < 300 && wq.size() < 1; n++)
			@(posedge clk_i);
		if (wq.size() < 1)
		begin
			chk(32'h0, 32'h1, "burst never began");
			tally_and_finish();
		end
		nmi <= 1'b1;
		@(posedge clk_i);
		nmi <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(32'(wq.size() > 0 && wq.size() < 16), 32'h1, "nmi stop");
		chk(32'(wq.size()), 32'(rq.size()), "whole transfers");
		chk({31'h0, bus_req}, 32'h0000_0000, "nmi release");
		ahb(1'b0, OFS_CHANNEL_CTRL, 32'h0000_0000, x);
		chk(x, 32'h0000_0003, "master cleared");
		$display("test nmi done");
		start(13'h0005, s, d, 8'h00, 16'h0003, 5'h17);
		pin_n <= 1'b0;
		repeat (60) @(posedge clk_i);
		chk(32'(wq.size()), 32'h1, "edge held low");
		pin_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		pin_n <= 1'b0;
		repeat (60) @(posedge clk_i);
		chk(32'(wq.size()), 32'h2, "edge again");
		pin_n <= 1'b1;
		start(13'h0005, s, d, 8'h00, 16'h0003, 5'h07);
		pin_n <= 1'b0;
		wait_dead(1);
		pin_n <= 1'b1;
		expect_xfers(13'h0005, s, d, 3, 0);
		$display("test request pin done");
		tally_and_finish();
	end
endmodule // testbench
